// ---- hdl/azsp_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - Zone flag is 1 while the axis position lies inside the zone.
// - Eight independent zones per axis, each with its own flag.
// - Zone spec word enables each zone and selects when bounds apply.
// - Each zone has a lower and an upper limit word.
// - Error count at or above warning value raises the warning flag.
// - In-position only when error count is within the width.
// - Feedforward term scaled by its gain is added to speed reference.
// - Per-axis backlash value is applied on negative travel.
// - Brake release waits the brake OFF time when port is a brake.
// - Unit parameters 0FA0 to 0FA9 are read-only.
// - Memory management words 1004 to 100D are read-only.
// - Machine parameter blocks 1068 to 10CB are read-only.
// - Coordinate blocks per axis are read and write.
// - Feed-rate blocks per axis sit at 1130, 1149, 1162, 117B.
// - Only time and ratio words of the feed-rate block take writes.
// - Zone blocks per axis are read and write.
// - Servo blocks per axis are read and write.
module azsp_top #(
    parameter int          TICK_CYC = azsp_pkg::TICK_CYC_DEF,
    parameter logic [15:0] OUTPORT  = 16'h000F
) (
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    input  wire azsp_pkg::azsp_bus_s  bus,
    output logic [15:0]               rdata,
    input  wire azsp_pkg::azsp_axin_s [3:0] axis_in,
    output logic [3:0][7:0]           zone_flag,
    output logic [3:0]                err_warn,
    output logic [3:0]                in_pos,
    output logic [3:0][15:0]          speed_ref,
    output logic [3:0][15:0]          bl_comp,
    output logic [3:0]                brake_out,
    output logic [3:0]                brake_done
);

    typedef struct packed {
        logic [15:0]           rdata;
        logic [3:0][7:0]       zflag;
        logic [3:0][7:0][15:0] lo;
        logic [3:0][7:0][15:0] hi;
        logic [3:0][7:0]       zen;
        logic [3:0]            warn;
        logic [3:0]            inpos;
        logic [3:0][15:0]      spd;
        logic [3:0][15:0]      blc;
        logic [3:0]            bcmd;
        logic [3:0]            bdone;
        logic [3:0][15:0]      bcnt;
        logic [31:0]           tcnt;
        logic                  tick;
    } azsp_state_s;

    azsp_state_s st;
    azsp_state_s next_st;
    logic [15:0] mem [0:azsp_pkg::MEM_WORDS-1];
    logic        wr_ok;
    logic        mem_rd;
    logic [8:0]  widx;

    // ****************************************************
    // Address decode
    // ****************************************************
    function automatic logic in_grp(input logic [15:0] a,
                                    input logic [15:0] base,
                                    input logic [15:0] len);
        logic        r;
        logic [15:0] b;
        r = 1'b0;
        b = base;
        for (int i = 0; i < 4; i++)
        begin
            if (a >= b && a < b + len)
            begin
                r = 1'b1;
            end
            b = b + azsp_pkg::AX_STRIDE;
        end
        return r;
    endfunction

    function automatic logic [15:0] absv(input logic [15:0] v);
        return v[15] ? 16'(-v) : v;
    endfunction

    // Read-only groups other than the 0FA6 port word and the 1300 status words, and unmapped words, fall through to zero reads
    always_comb
    begin
        wr_ok = in_grp(bus.addr, azsp_pkg::COORD_BASE,
                       azsp_pkg::COORD_LEN)
              | in_grp(bus.addr,
                       azsp_pkg::FEED_BASE + azsp_pkg::FEED_WR_OFS,
                       azsp_pkg::FEED_WR_LEN)
              | in_grp(bus.addr, azsp_pkg::ZONE_BASE,
                       azsp_pkg::ZONE_LEN)
              | in_grp(bus.addr, azsp_pkg::SERVO_BASE,
                       azsp_pkg::SERVO_LEN);
        mem_rd = wr_ok | in_grp(bus.addr, azsp_pkg::FEED_BASE,
                                azsp_pkg::FEED_LEN);
        widx = 9'(bus.addr - azsp_pkg::COORD_BASE);
    end

    // ****************************************************
    // Parameter store
    // ****************************************************
    // Held outside the state struct: it is a memory, not control state
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < azsp_pkg::MEM_WORDS; i++)
            begin
                mem[i] <= 16'h0000;
            end
        end
        else if (bus.wr && wr_ok)
        begin
            mem[widx] <= bus.wdata;
        end
    end

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb
    begin
        logic [15:0] zs;
        logic [15:0] ae;
        logic [15:0] dly;
        logic [31:0] acc;
        int          zb;
        int          sb;
        zs  = 16'h0000;
        ae  = 16'h0000;
        dly = 16'h0000;
        acc = 32'h0000_0000;
        zb  = 0;
        sb  = 0;
        next_st = st;

        // Register read, data stand in the following cycle only
        next_st.rdata = 16'h0000;
        if (bus.rd)
        begin
            if (mem_rd)
            begin
                next_st.rdata = mem[widx];
            end
            else if (bus.addr == azsp_pkg::UNIT_PORT)
            begin
                next_st.rdata = OUTPORT;
            end
            else if (bus.addr >= azsp_pkg::STAT_BASE &&
                     bus.addr < azsp_pkg::STAT_BASE + 16'h0004)
            begin
                for (int a = 0; a < 4; a++)
                begin
                    if (bus.addr[1:0] == 2'(a))
                    begin
                        next_st.rdata = {4'h0, st.bcmd[a], st.bdone[a],
                                         st.warn[a], st.inpos[a],
                                         st.zflag[a]};
                    end
                end
            end
        end

        // 1 ms tick paces the brake delays
        next_st.tick = 1'b0;
        if (st.tcnt >= 32'(TICK_CYC - 1))
        begin
            next_st.tcnt = 32'h0000_0000;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.tcnt = st.tcnt + 32'h0000_0001;
        end

        for (int a = 0; a < 4; a++)
        begin
            zb = azsp_pkg::ZONE_IDX + a * azsp_pkg::STRIDE;
            sb = azsp_pkg::SERVO_IDX + a * azsp_pkg::STRIDE;
            zs = mem[zb];
            ae = absv(axis_in[a].err);

            next_st.warn[a]  = ae >= mem[sb + azsp_pkg::SV_WARN];
            next_st.inpos[a] = ae <= mem[sb + azsp_pkg::SV_INPOS];

            // Feedforward skips the error path, goes straight to the sum
            acc = 32'($signed(mem[sb + azsp_pkg::SV_GAIN]))
                  * 32'($signed(axis_in[a].err))
                + 32'($signed(mem[sb + azsp_pkg::SV_FFGAIN]))
                  * 32'($signed(axis_in[a].ff));
            next_st.spd[a] = 16'($signed(acc) >>> azsp_pkg::GAIN_SHIFT);

            next_st.blc[a] = axis_in[a].dir_neg ?
                             mem[sb + azsp_pkg::SV_BLASH] : 16'h0000;

            // Timing bit set: new bounds take hold only in position
            next_st.zen[a] = zs[7:0];
            if (!zs[azsp_pkg::ZS_TIMING] || st.inpos[a])
            begin
                for (int k = 0; k < 8; k++)
                begin
                    next_st.lo[a][k] = mem[zb + 1 + 2 * k];
                    next_st.hi[a][k] = mem[zb + 2 + 2 * k];
                end
            end
            for (int k = 0; k < 8; k++)
            begin
                next_st.zflag[a][k] = st.zen[a][k]
                    && $signed(axis_in[a].pos) >= $signed(st.lo[a][k])
                    && $signed(axis_in[a].pos) <= $signed(st.hi[a][k]);
            end

            // Brake: command changes, then the done flag waits the delay
            dly = axis_in[a].brk_rel_req ? mem[sb + azsp_pkg::SV_BOFF]
                                         : mem[sb + azsp_pkg::SV_BON];
            if (axis_in[a].brk_rel_req != st.bcmd[a])
            begin
                next_st.bcmd[a]  = axis_in[a].brk_rel_req;
                next_st.bcnt[a]  = OUTPORT[a] ? dly : 16'h0000;
                next_st.bdone[a] = 1'b0;
            end
            else if (st.bcnt[a] == 16'h0000)
            begin
                next_st.bdone[a] = 1'b1;
            end
            else if (st.tick)
            begin
                next_st.bcnt[a] = st.bcnt[a] - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata      = st.rdata;
    assign zone_flag  = st.zflag;
    assign err_warn   = st.warn;
    assign in_pos     = st.inpos;
    assign speed_ref  = st.spd;
    assign bl_comp    = st.blc;
    assign brake_out  = st.bcmd;
    assign brake_done = st.bdone;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    zone_inside_a: assert property (
        (st.zen[0][0]
         && $signed(axis_in[0].pos) >= $signed(st.lo[0][0])
         && $signed(axis_in[0].pos) <= $signed(st.hi[0][0]))
        |=> zone_flag[0][0])
        else $error("zone flag missing inside zone");

    zone_disable_a: assert property (
        !st.zen[1][3] |=> !zone_flag[1][3])
        else $error("disabled zone flag set");

    zone_edge_a: assert property (
        (st.zen[3][6] && axis_in[3].pos == st.hi[3][6]
         && $signed(st.lo[3][6]) <= $signed(st.hi[3][6]))
        |=> zone_flag[3][6])
        else $error("upper limit not counted inside");

    mach_ro_a: assert property (
        (bus.wr && bus.addr == 16'h1068 && bus.wdata != 16'h0000)
        ##2 (bus.rd && bus.addr == 16'h1068) |=> rdata == 16'h0000)
        else $error("machine word took a write");

    servo_rw_a: assert property (
        (bus.wr && bus.addr == 16'h11F8) ##2
        (bus.rd && bus.addr == 16'h11F8) |=> rdata == $past(bus.wdata, 3))
        else $error("servo word not stored");

    feed_ro_a: assert property (
        (bus.rd && bus.addr == 16'h1130) |=> rdata == 16'h0000)
        else $error("read-only feed word changed");

    unit_port_a: assert property (
        (bus.rd && bus.addr == 16'h0FA6) |=> rdata == OUTPORT)
        else $error("output port word wrong");

    warn_level_a: assert property (
        (resetn
         && absv(axis_in[2].err) >= mem[azsp_pkg::SERVO_IDX + 50])
        |=> err_warn[2])
        else $error("error counter warning missed");

    inpos_level_a: assert property (
        (absv(axis_in[0].err) > mem[azsp_pkg::SERVO_IDX + 1])
        |=> !in_pos[0])
        else $error("in-position outside width");

    brake_wait_a: assert property (
        ($rose(brake_out[0]) && OUTPORT[0]
         && $past(mem[azsp_pkg::SERVO_IDX + 5]) != 16'h0000)
        |-> !brake_done[0] [*2])
        else $error("brake released without delay");

    brake_hold_a: assert property (
        ($fell(brake_out[0]) && OUTPORT[0]
         && $past(mem[azsp_pkg::SERVO_IDX + 6]) != 16'h0000)
        |-> !brake_done[0] [*2])
        else $error("brake engaged without delay");

    zone_below_a: assert property (
        ($signed(axis_in[1].pos) < $signed(st.lo[1][7]))
        |=> !zone_flag[1][7])
        else $error("zone flag set below lower limit");

    mmgt_ro_a: assert property (
        (bus.rd && bus.addr >= azsp_pkg::MMGT_FIRST
         && bus.addr <= azsp_pkg::MMGT_LAST) |=> rdata == 16'h0000)
        else $error("memory management word not zero");

    unit_ro_a: assert property (
        (bus.rd && bus.addr >= azsp_pkg::UNIT_FIRST
         && bus.addr <= azsp_pkg::UNIT_LAST
         && bus.addr != azsp_pkg::UNIT_PORT) |=> rdata == 16'h0000)
        else $error("unit word not zero");

endmodule

// ---- hdl/azsp_pkg.sv ----
package azsp_pkg;

    // ****************************************************
    // Parameter map, word addresses
    // ****************************************************
    localparam logic [15:0] UNIT_FIRST  = 16'h0FA0;
    localparam logic [15:0] UNIT_LAST   = 16'h0FA9;
    localparam logic [15:0] UNIT_PORT   = 16'h0FA6;
    localparam logic [15:0] MMGT_FIRST  = 16'h1004;
    localparam logic [15:0] MMGT_LAST   = 16'h100D;
    localparam logic [15:0] MACH_FIRST  = 16'h1068;
    localparam logic [15:0] MACH_LAST   = 16'h10CB;
    localparam logic [15:0] COORD_BASE  = 16'h10CC;
    localparam logic [15:0] FEED_BASE   = 16'h1130;
    localparam logic [15:0] ZONE_BASE   = 16'h1194;
    localparam logic [15:0] SERVO_BASE  = 16'h11F8;
    localparam logic [15:0] AX_STRIDE   = 16'h0019;
    localparam logic [15:0] COORD_LEN   = 16'h0004;
    localparam logic [15:0] FEED_LEN    = 16'h0014;
    localparam logic [15:0] FEED_WR_OFS = 16'h0008;
    localparam logic [15:0] FEED_WR_LEN = 16'h000C;
    localparam logic [15:0] ZONE_LEN    = 16'h0011;
    localparam logic [15:0] SERVO_LEN   = 16'h000A;
    localparam logic [15:0] STAT_BASE   = 16'h1300;
    localparam logic [15:0] MEM_LAST    = 16'h124C;
    localparam int          MEM_WORDS   = 385;

    // Word indices inside the writable store, relative to COORD_BASE
    localparam int ZONE_IDX  = 200;
    localparam int SERVO_IDX = 300;
    localparam int STRIDE    = 25;
    localparam int SV_WARN   = 0;
    localparam int SV_INPOS  = 1;
    localparam int SV_GAIN   = 2;
    localparam int SV_FFGAIN = 3;
    localparam int SV_BLASH  = 4;
    localparam int SV_BOFF   = 5;
    localparam int SV_BON    = 6;
    localparam int ZS_TIMING = 8;
    localparam int GAIN_SHIFT = 8;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_NS  = 50;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } azsp_bus_s;

    typedef struct packed {
        logic [15:0] pos;
        logic [15:0] err;
        logic [15:0] ff;
        logic        dir_neg;
        logic        brk_rel_req;
    } azsp_axin_s;

endpackage

// ---- verif/azsp_host_model.sv ----
`timescale 1ns/1ps
module azsp_host_model (
    input  wire logic           core_clk,
    output azsp_pkg::azsp_bus_s bus,
    input  wire logic [15:0]    rdata
);
    // ****************************************************
    // Word access
    // ****************************************************
    initial bus = '0;

    // Released lines carry the inverse so stale values never look valid
    task automatic word_write(input logic [15:0] a,
                              input logic [15:0] d);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge core_clk);
        bus.wr    <= 1'b0;
        bus.addr  <= ~a;
        bus.wdata <= ~d;
        @(posedge core_clk);
    endtask

    task automatic word_read(input logic [15:0] a,
                             output logic [15:0] d);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge core_clk);
        bus.rd   <= 1'b0;
        bus.addr <= ~a;
        @(posedge core_clk);
        d = rdata;
    endtask

    // A parameter pair moves as two words, at a and a + 1
    task automatic xfer_write(input logic [15:0] a, input logic [15:0] d0,
                              input logic [15:0] d1);
        word_write(a, d0);
        word_write(a + 16'h0001, d1);
    endtask
endmodule

// ---- verif/axis_zone_servo_params_tb_top.sv ----
`timescale 1ns/1ps
module axis_zone_servo_params_tb_top;
    localparam int          TICK  = 4;
    localparam logic [15:0] PORTS = 16'h000B;

    logic                       core_clk;
    logic                       resetn;
    azsp_pkg::azsp_bus_s        bus;
    logic [15:0]                rdata;
    azsp_pkg::azsp_axin_s [3:0] axis_in;
    logic [3:0][7:0]            zone_flag;
    logic [3:0]                 err_warn;
    logic [3:0]                 in_pos;
    logic [3:0][15:0]           speed_ref;
    logic [3:0][15:0]           bl_comp;
    logic [3:0]                 brake_out;
    logic [3:0]                 brake_done;
    logic [15:0]                rd_v;
    int                         n_fail;
    int                         compares;
    int                         cycles;

    // Address, write data, expected read back
    logic [47:0] rows [20] = '{
        {16'h11F8, 16'hA5A5, 16'hA5A5}, {16'h124C, 16'h0F0F, 16'h0F0F},
        {16'h1211, 16'h1111, 16'h1111}, {16'h10CC, 16'h2222, 16'h2222},
        {16'h111A, 16'h3333, 16'h3333}, {16'h11A4, 16'h4444, 16'h4444},
        {16'h11DF, 16'h5555, 16'h5555}, {16'h1138, 16'h6666, 16'h6666},
        {16'h118E, 16'h7777, 16'h7777}, {16'h1151, 16'h7878, 16'h7878},
        {16'h1130, 16'h8888, 16'h0000}, {16'h1137, 16'h9999, 16'h0000},
        {16'h0FA0, 16'hAAAA, 16'h0000}, {16'h0FA9, 16'hBBBB, 16'h0000},
        {16'h1004, 16'hCCCC, 16'h0000}, {16'h100D, 16'hDDDD, 16'h0000},
        {16'h1068, 16'hEEEE, 16'h0000}, {16'h10CB, 16'hFFFF, 16'h0000},
        {16'h0FA6, 16'h1234, PORTS},    {16'h1250, 16'h1357, 16'h0000}};
    // X position, Y position, X flags, Y flags
    logic [47:0] zp [5] = '{
        {16'h000F, 16'hFFFA, 16'h0000}, {16'h0010, 16'hFFFB, 16'h0180},
        {16'h0020, 16'h0005, 16'h0180}, {16'h0021, 16'h0006, 16'h0000},
        {16'h0018, 16'h0000, 16'h0180}};
    // Error count, then warning and in-position
    logic [17:0] ev [6] = '{
        {16'h0005, 2'b01}, {16'hFFFB, 2'b01}, {16'hFFFA, 2'b00},
        {16'h0063, 2'b00}, {16'h0064, 2'b10}, {16'hFF9C, 2'b10}};

    azsp_top #(
        .TICK_CYC (TICK),
        .OUTPORT  (PORTS)
    ) u_dut (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .bus        (bus),
        .rdata      (rdata),
        .axis_in    (axis_in),
        .zone_flag  (zone_flag),
        .err_warn   (err_warn),
        .in_pos     (in_pos),
        .speed_ref  (speed_ref),
        .bl_comp    (bl_comp),
        .brake_out  (brake_out),
        .brake_done (brake_done)
    );

    azsp_host_model u_host (
        .core_clk (core_clk),
        .bus      (bus),
        .rdata    (rdata)
    );

    // ****************************************************
    // Checking
    // ****************************************************
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic settle;
        repeat (3) @(posedge core_clk);
    endtask

    // Axis 2 port is not a brake, so its delay word must be ignored
    task automatic brake_run(input logic req, input int lo, input int hi);
        int n0;
        int n2;
        n0 = 0;
        n2 = 0;
        axis_in[0].brk_rel_req <= req;
        axis_in[2].brk_rel_req <= req;
        @(posedge core_clk);
        for (int i = 1; i <= 20; i++)
        begin
            @(posedge core_clk);
            if (i == 1)
                chk_bit(brake_out[0], req);
            if (n0 == 0 && brake_done[0] === 1'b1)
                n0 = i;
            if (n2 == 0 && brake_done[2] === 1'b1)
                n2 = i;
        end
        chk_bit(n0 >= lo && n0 <= hi, 1'b1);
        chk_bit(n2 >= 1 && n2 <= 3, 1'b1);
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ****************************************************
    // Sequence
    // ****************************************************
    initial
    begin
        resetn   = 1'b0;
        axis_in  = '0;
        n_fail   = 0;
        compares = 0;
        cycles   = 0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        u_host.word_read(16'h11F8, rd_v);
        chk_word(rd_v, 16'h0000);
        for (int i = 0; i < 20; i++)
        begin
            u_host.word_write(rows[i][47:32], rows[i][31:16]);
            u_host.word_read(rows[i][47:32], rd_v);
            chk_word(rd_v, rows[i][15:0]);
        end
        u_host.word_write(16'h1194, 16'h0001);
        u_host.xfer_write(16'h1195, 16'h0010, 16'h0020);
        u_host.word_write(16'h11AD, 16'h0080);
        u_host.xfer_write(16'h11BC, 16'hFFFB, 16'h0005);
        for (int i = 0; i < 5; i++)
        begin
            axis_in[0].pos <= zp[i][47:32];
            axis_in[1].pos <= zp[i][31:16];
            settle();
            chk_word({zone_flag[0], zone_flag[1]}, zp[i][15:0]);
        end
        // U axis zones have all limits at zero and stay enabled from the table
        u_host.word_write(16'h1194, 16'h0000);
        settle();
        chk_word({zone_flag[0], zone_flag[3]}, 16'h0055);
        u_host.xfer_write(16'h11F8, 16'h0064, 16'h0005);
        u_host.xfer_write(16'h11FA, 16'h0100, 16'h0200);
        u_host.word_write(16'h11FC, 16'h0033);
        for (int i = 0; i < 6; i++)
        begin
            axis_in[0].err <= ev[i][17:2];
            settle();
            chk_word({14'h0000, err_warn[0], in_pos[0]}, {14'h0000, ev[i][1:0]});
        end
        axis_in[0].err     <= 16'h0003;
        axis_in[0].ff      <= 16'h0002;
        axis_in[0].dir_neg <= 1'b1;
        settle();
        chk_word(speed_ref[0], 16'h0007);
        chk_word(bl_comp[0], 16'h0033);
        axis_in[0].err     <= 16'h0000;
        axis_in[0].ff      <= 16'hFFFE;
        axis_in[0].dir_neg <= 1'b0;
        settle();
        chk_word(speed_ref[0], 16'hFFFC);
        chk_word(bl_comp[0], 16'h0000);
        u_host.xfer_write(16'h11FD, 16'h0002, 16'h0003);
        u_host.xfer_write(16'h122F, 16'h0002, 16'h0003);
        brake_run(1'b1, 5, 11);
        brake_run(1'b0, 9, 15);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        u_host.word_read(16'h11F8, rd_v);
        chk_word(rd_v, 16'h0000);
        tally_and_finish();
    end
endmodule
